// [verilog/clsc_core.sv]
// module: loop counters, status flags, priority and core configuration
// Function
// - table page gives program address top byte
// - visibility page maps program region into data
// - repeat loads count, runs count plus one
// - loop counter loads count, runs plus one
// - loop start captures next instruction address
// - loop end redirects fetch to start
// - loop end captures instruction end expression
// - carry reports not-borrow on subtraction
// - zero flag sticky for carry-input instructions
// - shadow push saves, pop restores flags
// - low status byte stacked; return restores only its level and repeat bits
// - loop flag set on start, cleared finish
// - repeat flag changed only by repeats and exception return
// - loop flags read-only; early exit bit
// - cleared stacked repeat flag stops repeating
// - guard overflow only with super or no saturation
// - saturation flags sticky until software clears
// - combined flags are ORs; clear clears both
// - priority is three bits plus trap bit
// - accept only higher level, then raise level
// - core configuration resets to 0020 hex
// - loop and push/pop use own shadows
// - shadows one deep, one hardware nesting
// - push/pop covers w0-w3 and five flags
// - early exit ends loop, reads zero
// - nesting field gives loop depth
`default_nettype none
module clsc_core (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic      [31:0]             readdata,
  output logic                         waitrequest,
  input  wire clsc_pkg::clsc_instr_type instr,
  input  wire clsc_pkg::clsc_alu_type   alu,
  input  wire clsc_pkg::clsc_exc_type   exc,
  input  wire logic [63:0]             wreg_low,
  input  wire logic [15:0]             data_addr,
  output logic      [7:0]              table_page_out,
  output logic                         psv_hit,
  output logic      [23:0]             psv_prog_addr,
  output logic                         loop_redirect,
  output logic      [23:0]             loop_target,
  output logic                         repeat_hold,
  output logic                         exc_accept,
  output logic      [3:0]              cpu_level,
  output logic      [7:0]              stacked_low,
  output logic      [63:0]             wreg_restore,
  output logic      [4:0]              flag_restore,
  output logic      [15:0]             core_mode
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]  table_page_upper;    // table page
  logic [7:0]  visibility_page;     // visibility page
  logic [13:0] repeat_counter;      // repeat count
  logic [13:0] loop_counter;        // loop count
  logic [23:0] loop_start_address;  // loop start
  logic [23:0] loop_end_address;    // loop end
  logic [13:0] sh_count;            // loop count shadow
  logic [23:0] sh_start;            // loop start shadow
  logic [23:0] sh_end;              // loop end shadow
  logic [4:0]  sh_flags;            // dc n ov z c shadow
  logic [63:0] sh_wreg;             // w0-w3 shadow
  logic        c, z, ov, n, dc;     // mcu flags
  logic        repeat_running_flag; // repeat active
  logic        loop_running_flag;   // loop active
  logic [2:0]  priority_level_low;  // level bits
  logic        acc_one_guard_overflow, acc_two_guard_overflow;
  logic        acc_one_sticky_sat, acc_two_sticky_sat;
  logic [2:0]  loop_nesting_field;  // depth
  logic        early_exit_control;  // pending termination
  logic        trap_level_bit;      // trap in service
  logic        multiplier_sign_select;
  logic [6:0]  cfg_low;             // low config bits without trap
  logic        ack;                 // bus answer cycle
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        req       = read | write;
  wire        wr_now    = write & ack;
  wire [15:0] wd        = writedata[15:0];
  wire        wr_tbl    = wr_now & (address == clsc_pkg::OFS_TBLPAGE);
  wire        wr_vis    = wr_now & (address == clsc_pkg::OFS_VISPAGE);
  wire        wr_rep    = wr_now & (address == clsc_pkg::OFS_REPCNT);
  wire        wr_loop   = wr_now & (address == clsc_pkg::OFS_LOOPCNT);
  wire        wr_lstart = wr_now & (address == clsc_pkg::OFS_LSTART);
  wire        wr_lend   = wr_now & (address == clsc_pkg::OFS_LEND);
  wire        wr_stat   = wr_now & (address == clsc_pkg::OFS_STATUS);
  wire        wr_core   = wr_now & (address == clsc_pkg::OFS_CORE);
  // one wait state then answer
  assign waitrequest = req & ~ack;
  // ----------------------------------------
  // assembled registers
  // ----------------------------------------
  // combined flags as ORs
  wire comb_ovf = acc_one_guard_overflow | acc_two_guard_overflow;
  wire comb_sat = acc_one_sticky_sat | acc_two_sticky_sat;
  wire [15:0] status_word = {acc_one_guard_overflow, acc_two_guard_overflow,
                             acc_one_sticky_sat, acc_two_sticky_sat, comb_ovf, comb_sat,
                             loop_running_flag, dc, priority_level_low,
                             repeat_running_flag, n, ov, z, c};
  wire [15:0] core_word = {3'h0, multiplier_sign_select, 1'b0, loop_nesting_field,
                           cfg_low[6:3], trap_level_bit, cfg_low[2:0]};
  wire [15:0] rd_mux =
    (address == clsc_pkg::OFS_TBLPAGE) ? {8'h00, table_page_upper} :
    (address == clsc_pkg::OFS_VISPAGE) ? {8'h00, visibility_page} :
    (address == clsc_pkg::OFS_REPCNT)  ? {2'h0, repeat_counter} :
    (address == clsc_pkg::OFS_LOOPCNT) ? {2'h0, loop_counter} :
    (address == clsc_pkg::OFS_LSTART)  ? loop_start_address[15:0] :
    (address == clsc_pkg::OFS_LEND)    ? loop_end_address[15:0] :
    (address == clsc_pkg::OFS_STATUS)  ? status_word :
    (address == clsc_pkg::OFS_CORE)    ? core_word : 16'h0000;
  // ----------------------------------------
  // fetch-side outputs
  // ----------------------------------------
  // top program address byte
  assign table_page_out = table_page_upper;
  // upper data half maps through the page
  assign psv_hit       = cfg_low[2] & data_addr[15];
  assign psv_prog_addr = {1'b0, visibility_page, data_addr[14:0]};
  wire at_end   = instr.exec & loop_running_flag & (instr.pc == loop_end_address);
  wire loop_fin = at_end & ((loop_counter == 14'h0000) | early_exit_control);
  assign loop_redirect = at_end & ~loop_fin;
  assign loop_target   = loop_start_address;
  assign repeat_hold   = repeat_running_flag & (repeat_counter != 14'h0000);
  assign cpu_level     = {trap_level_bit, priority_level_low};
  assign exc_accept    = exc.req & (exc.req_level > cpu_level);
  // low status byte pushed on entry
  assign stacked_low   = status_word[7:0];
  assign wreg_restore  = sh_wreg;
  assign flag_restore  = sh_flags;
  assign core_mode     = core_word;
  // ----------------------------------------
  // flag next values
  // ----------------------------------------
  // subtract stores not-borrow in carry
  wire alu_c = alu.sub ? ~alu.c : alu.c;
  // carry-input ops only keep zero cleared
  wire alu_z = alu.cin_op ? (z & alu.z) : alu.z;
  wire sat_mode_select    = cfg_low[3];
  wire acc_one_sat_enable = cfg_low[6];
  wire acc_two_sat_enable = cfg_low[5];
  // guard overflow visible only without normal saturation
  wire g1 = alu.guard_ovf[0] & (sat_mode_select | ~acc_one_sat_enable);
  wire g2 = alu.guard_ovf[1] & (sat_mode_select | ~acc_two_sat_enable);
  // software may clear, never set; set wins
  wire clr_sab = wr_stat & ~wd[clsc_pkg::ST_SAB];
  wire clr_sa  = wr_stat & (~wd[clsc_pkg::ST_SA] | ~wd[clsc_pkg::ST_SAB]);
  wire clr_sb  = wr_stat & (~wd[clsc_pkg::ST_SB] | ~wd[clsc_pkg::ST_SAB]);
  wire next_sa = alu.msb_ovf[0] | (acc_one_sticky_sat & ~clr_sa & ~clr_sab);
  wire next_sb = alu.msb_ovf[1] | (acc_two_sticky_sat & ~clr_sb & ~clr_sab);
  wire [4:0] bus_flags = wr_stat ? {wd[8], wd[3:0]} : {dc, n, ov, z, c};
  // pop restores, alu updates, else bus value
  wire [4:0] next_flags = instr.pop_s ? sh_flags :
                          alu.upd     ? {alu.dc, alu.n, alu.ov, alu_z, alu_c} :
                                        bus_flags;
  // ----------------------------------------
  // bus answer register
  // ----------------------------------------
  // answer on second cycle, data from flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack      <= 1'b0;
      readdata <= 32'h00000000;
    end
    else
    begin
      ack      <= req & ~ack;
      readdata <= {16'h0000, rd_mux};
    end
  end
  // ----------------------------------------
  // pages and mcu flags
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_page_upper <= 8'h00;
      visibility_page  <= 8'h00;
      {dc, n, ov, z, c} <= 5'h00;
    end
    else
    begin
      if (wr_tbl)
        table_page_upper <= wd[7:0];
      if (wr_vis)
        visibility_page <= wd[7:0];
      {dc, n, ov, z, c} <= next_flags;
    end
  end
  // ----------------------------------------
  // push/pop shadow
  // ----------------------------------------
  // w0-w3 with five flags
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_flags <= 5'h00;
      sh_wreg  <= 64'h0000000000000000;
    end
    else if (instr.push_s)
    begin
      sh_flags <= {dc, n, ov, z, c};
      sh_wreg  <= wreg_low;
    end
  end
  // ----------------------------------------
  // dsp flags
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_one_guard_overflow <= 1'b0;
      acc_two_guard_overflow <= 1'b0;
      acc_one_sticky_sat     <= 1'b0;
      acc_two_sticky_sat     <= 1'b0;
    end
    else
    begin
      // guard overflow follows each accumulator write
      if (alu.acc_upd[0])
        acc_one_guard_overflow <= g1;
      if (alu.acc_upd[1])
        acc_two_guard_overflow <= g2;
      acc_one_sticky_sat <= next_sa;
      acc_two_sticky_sat <= next_sb;
    end
  end
  // ----------------------------------------
  // priority and configuration
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      priority_level_low     <= 3'h0;
      trap_level_bit         <= 1'b0;
      cfg_low                <= {clsc_pkg::CFG_LO_RST[7:4], clsc_pkg::CFG_LO_RST[2:0]};
      multiplier_sign_select <= clsc_pkg::CFG_LO_RST[0];
    end
    else
    begin
      // level rises to the serviced exception
      if (exc.take)
        priority_level_low <= exc.req_level[2:0];
      else if (exc.ret)
        priority_level_low <= exc.ret_low[7:5];
      else if (wr_stat)
        priority_level_low <= wd[7:5];
      // trap sets, software only clears; set wins
      if (exc.take & exc.req_level[3])
        trap_level_bit <= 1'b1;
      else if (wr_core & ~wd[clsc_pkg::CFG_TRAP])
        trap_level_bit <= 1'b0;
      if (wr_core)
      begin
        cfg_low                <= {wd[7:4], wd[2:0]};
        multiplier_sign_select <= wd[clsc_pkg::CFG_US];
      end
    end
  end
  // ----------------------------------------
  // repeat control
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      repeat_counter      <= 14'h0000;
      repeat_running_flag <= 1'b0;
    end
    // load count, target then runs count plus one
    else if (instr.rep_go)
    begin
      repeat_counter      <= instr.rep_val;
      // set as the repeated instruction begins
      repeat_running_flag <= 1'b1;
    end
    // restored stacked flag may stop repeating
    else if (exc.ret)
      repeat_running_flag <= exc.ret_low[4];
    else if (instr.exec & repeat_running_flag)
    begin
      if (repeat_counter == 14'h0000)
        repeat_running_flag <= 1'b0;
      else
        repeat_counter <= repeat_counter - 14'h0001;
    end
    else if (wr_rep)
      repeat_counter <= wd[13:0];
  end
  // ----------------------------------------
  // hardware loop control
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop_counter       <= 14'h0000;
      loop_start_address <= 24'h000000;
      loop_end_address   <= 24'h000000;
      sh_count           <= 14'h0000;
      sh_start           <= 24'h000000;
      sh_end             <= 24'h000000;
      loop_running_flag  <= 1'b0;
      loop_nesting_field <= 3'h0;
      early_exit_control <= 1'b0;
    end
    else if (instr.do_go)
    begin
      // loop registers saved into their shadow
      // single entry, one nested level in hardware
      if (loop_running_flag)
      begin
        sh_count <= loop_counter;
        sh_start <= loop_start_address;
        sh_end   <= loop_end_address;
      end
      // count from literal or low source bits
      loop_counter       <= instr.do_cnt;
      loop_start_address <= instr.pc + clsc_pkg::PC_STEP;
      loop_end_address   <= instr.do_end;
      loop_running_flag  <= 1'b1;
      if (loop_nesting_field != clsc_pkg::DL_MAX)
        loop_nesting_field <= loop_nesting_field + 3'h1;
      early_exit_control <= 1'b0;
    end
    else if (loop_fin)
    begin
      early_exit_control <= 1'b0;
      // back to the outer loop from shadow
      if (loop_nesting_field > 3'h1)
      begin
        loop_counter       <= sh_count;
        loop_start_address <= sh_start;
        loop_end_address   <= sh_end;
        loop_nesting_field <= loop_nesting_field - 3'h1;
      end
      else
      begin
        loop_running_flag  <= 1'b0;
        loop_nesting_field <= 3'h0;
      end
    end
    else if (at_end)
      loop_counter <= loop_counter - 14'h0001;
    else
    begin
      if (wr_loop)
        loop_counter <= wd[13:0];
      if (wr_lstart)
        loop_start_address <= {8'h00, wd};
      if (wr_lend)
        loop_end_address <= {8'h00, wd};
      if (wr_core & wd[clsc_pkg::CFG_EDT])
        early_exit_control <= 1'b1;
      // only the low depth bit is writable
      if (wr_core)
        loop_nesting_field[0] <= wd[clsc_pkg::CFG_DL0];
    end
  end
endmodule // clsc_core
`default_nettype wire

// [pkg/clsc_pkg.sv]
// package: constants and carriers for the core loop/status control block
`default_nettype none
package clsc_pkg;
  // ----------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_TBLPAGE = 8'h00;
  localparam logic [7:0] OFS_VISPAGE = 8'h04;
  localparam logic [7:0] OFS_REPCNT  = 8'h08;
  localparam logic [7:0] OFS_LOOPCNT = 8'h0c;
  localparam logic [7:0] OFS_LSTART  = 8'h10;
  localparam logic [7:0] OFS_LEND    = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_CORE    = 8'h1c;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int             CFG_US      = 12;
  localparam int             CFG_EDT     = 11;
  localparam int             CFG_DL0     = 8;
  localparam int             CFG_TRAP    = 3;
  localparam int             ST_SA       = 13;
  localparam int             ST_SB       = 12;
  localparam int             ST_SAB      = 10;
  localparam logic [7:0]     CFG_LO_RST  = 8'h20;
  localparam logic [23:0]    PC_STEP     = 24'h000002;
  localparam logic [2:0]     DL_MAX      = 3'h7;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  // one executed instruction's effect on this block
  typedef struct packed {
    logic        exec;       // instruction completes this cycle
    logic [23:0] pc;         // its address
    logic        rep_go;     // repeat instruction
    logic [13:0] rep_val;    // literal or working register
    logic        do_go;      // hardware loop instruction
    logic [13:0] do_cnt;     // literal or low bits of source
    logic [23:0] do_end;     // loop end address expression
    logic        push_s;     // shadow push
    logic        pop_s;      // shadow pop
  } clsc_instr_type;
  // mcu alu and dsp adder results
  typedef struct packed {
    logic       upd;         // mcu flags update
    logic       sub;         // subtract class
    logic       cin_op;      // uses carry or borrow input
    logic       c;           // carry out, or borrow out when sub
    logic       z;
    logic       ov;
    logic       n;
    logic       dc;
    logic [1:0] acc_upd;     // accumulator one/two written
    logic [1:0] guard_ovf;   // overflow into bits 39..32
    logic [1:0] msb_ovf;     // overflow out of bit 39
  } clsc_alu_type;
  // exception traffic
  typedef struct packed {
    logic       req;         // exception pending
    logic [3:0] req_level;   // its level
    logic       take;        // entry happens
    logic       ret;         // return happens
    logic [7:0] ret_low;     // low status byte off the stack
  } clsc_exc_type;
endpackage : clsc_pkg
`default_nettype wire

// [bench/clsc_core_monitor.sv]
// checker: port-level properties of the loop, status and configuration block
`default_nettype none
module clsc_core_monitor (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     read,
  input wire logic                     write,
  input wire logic                     waitrequest,
  input wire clsc_pkg::clsc_instr_type instr,
  input wire clsc_pkg::clsc_exc_type   exc,
  input wire logic [15:0]              data_addr,
  input wire logic                     psv_hit,
  input wire logic [23:0]              psv_prog_addr,
  input wire logic [23:0]              loop_target,
  input wire logic                     repeat_hold,
  input wire logic                     exc_accept,
  input wire logic [3:0]               cpu_level,
  input wire logic [15:0]              core_mode
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait state");
  a_cfg_reset_value: assert property ($rose(rst_n) |-> core_mode == 16'h0020)
    else $error("core configuration not 0020 after reset");
  a_vis_map: assert property ((core_mode[2] && data_addr[15]) |->
    psv_hit && psv_prog_addr[14:0] == data_addr[14:0]) else $error("visibility map wrong");
  a_exit_reads_zero: assert property (!core_mode[11])
    else $error("early exit bit reads one");
  a_accept_compare: assert property (exc_accept == (exc.req && exc.req_level > cpu_level))
    else $error("exception accept compare wrong");
  a_level_raise: assert property (exc.take |=> cpu_level == $past(exc.req_level))
    else $error("cpu level not raised to exception level");
  a_start_capture: assert property (instr.do_go |=> loop_target == $past(instr.pc) + 24'h2)
    else $error("loop start not next instruction");
  a_depth_first: assert property (instr.do_go && core_mode[10:8] == 3'h0 |=>
    core_mode[10:8] == 3'h1) else $error("nesting field not one");
  a_repeat_starts: assert property (instr.rep_go && instr.rep_val != 14'h0 |=> repeat_hold)
    else $error("repeat not active after load");
  c_loop: cover property (instr.do_go);
  c_trap: cover property (exc.take && exc.req_level[3]);
  c_vis: cover property (psv_hit);
endmodule // clsc_core_monitor
bind clsc_core clsc_core_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .read(read),
  .write(write), .waitrequest(waitrequest), .instr(instr), .exc(exc), .data_addr(data_addr),
  .psv_hit(psv_hit), .psv_prog_addr(psv_prog_addr), .loop_target(loop_target),
  .repeat_hold(repeat_hold), .exc_accept(exc_accept), .cpu_level(cpu_level),
  .core_mode(core_mode));
`default_nettype wire

// [bench/tb_core_loop_status_control.sv]
// testbench: directed scenarios for the loop, status and configuration block
`default_nettype none
module tb_core_loop_status_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     mclk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]               address = 8'h00, table_page_out, stacked_low;
  logic [31:0]              writedata = 32'h0, readdata;
  logic                     waitrequest, psv_hit, loop_redirect, repeat_hold, exc_accept;
  clsc_pkg::clsc_instr_type instr = '0;
  clsc_pkg::clsc_alu_type   alu = '0;
  clsc_pkg::clsc_exc_type   exc = '0;
  logic [63:0]              wreg_low = 64'h0123456789abcdef, wreg_restore;
  logic [15:0]              data_addr = 16'h8123, core_mode;
  logic [23:0]              psv_prog_addr, loop_target;
  logic [3:0]               cpu_level;
  logic [4:0]               flag_restore;
  int                       bad_count = 0, checks = 0;
  clsc_core i_dut (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .instr(instr), .alu(alu), .exc(exc), .wreg_low(wreg_low), .data_addr(data_addr),
    .table_page_out(table_page_out), .psv_hit(psv_hit), .psv_prog_addr(psv_prog_addr),
    .loop_redirect(loop_redirect), .loop_target(loop_target), .repeat_hold(repeat_hold),
    .exc_accept(exc_accept), .cpu_level(cpu_level), .stacked_low(stacked_low),
    .wreg_restore(wreg_restore), .flag_restore(flag_restore), .core_mode(core_mode));
  // 100 ns clock
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, d};
    // only the watchdog ends a wait
    do
    begin
      @(posedge mclk);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // let the answer edge settle before any check
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // end every pulse at the next edge
  task automatic tick;
    @(posedge mclk);
    instr <= '0;
    alu <= '0;
    exc.take <= 1'b0;
    exc.ret <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic op(input clsc_pkg::clsc_alu_type a);
    @(posedge mclk);
    alu <= a;
    tick;
  endtask
  task automatic do_loop(input logic [23:0] p, input logic [13:0] c, input logic [23:0] e);
    @(posedge mclk);
    instr <= '{exec:1'b1, pc:p, do_go:1'b1, do_cnt:c, do_end:e, default:'0};
    tick;
  endtask
  // executed instruction; e = {redirect, repeat hold} seen meanwhile
  task automatic exe(input logic [23:0] p, input logic [1:0] e);
    @(posedge mclk);
    instr.exec <= 1'b1;
    instr.pc <= p;
    @(negedge mclk);
    chk(32'({loop_redirect, repeat_hold}), 32'(e));
    tick;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_cfg;
    rd(clsc_pkg::OFS_CORE, 32'h0020);
    rd(8'h20, 32'h0);
    wr(clsc_pkg::OFS_TBLPAGE, 16'h00a5);
    chk(32'(table_page_out), 32'ha5);
    wr(clsc_pkg::OFS_VISPAGE, 16'h0012);
    wr(clsc_pkg::OFS_CORE, 16'h0824);
    chk({7'h0, psv_hit, psv_prog_addr}, 32'h01090123);
    rd(clsc_pkg::OFS_CORE, 32'h0024);
    chk(32'(core_mode), 32'h0024);
  endtask
  task automatic t_loop;
    do_loop(24'h100, 14'h1, 24'h110);
    rd(clsc_pkg::OFS_LSTART, 32'h0102);
    rd(clsc_pkg::OFS_LEND, 32'h0110);
    rd(clsc_pkg::OFS_LOOPCNT, 32'h1);
    rd(clsc_pkg::OFS_STATUS, 32'h0200);
    do_loop(24'h104, 14'h0, 24'h108);
    rd(clsc_pkg::OFS_CORE, 32'h0224);
    exe(24'h108, 2'b00);
    rd(clsc_pkg::OFS_LEND, 32'h0110);
    rd(clsc_pkg::OFS_CORE, 32'h0124);
    exe(24'h110, 2'b10);
    chk(32'(loop_target), 32'h102);
    exe(24'h110, 2'b00);
    rd(clsc_pkg::OFS_STATUS, 32'h0);
    // early exit ends a long loop at its first end pass
    do_loop(24'h300, 14'h5, 24'h304);
    wr(clsc_pkg::OFS_CORE, 16'h0924);
    exe(24'h304, 2'b00);
    rd(clsc_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic t_rep;
    @(posedge mclk);
    instr <= '{rep_go:1'b1, rep_val:14'h2, default:'0};
    tick;
    rd(clsc_pkg::OFS_REPCNT, 32'h2);
    for (int i = 0; i < 3; i++) exe(24'h200, {1'b0, i < 2});
    rd(clsc_pkg::OFS_STATUS, 32'h0);
    @(posedge mclk);
    instr <= '{rep_go:1'b1, rep_val:14'h5, default:'0};
    tick;
    @(posedge mclk);
    exc <= '{ret:1'b1, default:'0};
    tick;
    rd(clsc_pkg::OFS_STATUS, 32'h0);
    chk(32'(repeat_hold), 32'h0);
  endtask
  task automatic t_alu;
    op('{upd:1'b1, sub:1'b1, default:'0});
    rd(clsc_pkg::OFS_STATUS, 32'h0001);
    op('{upd:1'b1, n:1'b1, default:'0});
    op('{upd:1'b1, cin_op:1'b1, z:1'b1, n:1'b1, c:1'b1, default:'0});
    rd(clsc_pkg::OFS_STATUS, 32'h0009);
    @(posedge mclk);
    instr.push_s <= 1'b1;
    tick;
    op('{upd:1'b1, z:1'b1, ov:1'b1, dc:1'b1, default:'0});
    chk({flag_restore, wreg_restore[26:0]}, {5'h9, 27'h1abcdef});
    chk(wreg_restore[63:32], 32'h01234567);
    @(posedge mclk);
    instr.pop_s <= 1'b1;
    tick;
    rd(clsc_pkg::OFS_STATUS, 32'h0009);
    chk(32'(stacked_low), 32'h09);
    wr(clsc_pkg::OFS_STATUS, 16'h0210);
    rd(clsc_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic t_dsp;
    op('{acc_upd:2'b01, guard_ovf:2'b01, msb_ovf:2'b01, default:'0});
    rd(clsc_pkg::OFS_STATUS, 32'hac00);
    op('{acc_upd:2'b01, default:'0});
    rd(clsc_pkg::OFS_STATUS, 32'h2400);
    wr(clsc_pkg::OFS_CORE, 16'h00a4);
    op('{acc_upd:2'b01, guard_ovf:2'b01, default:'0});
    rd(clsc_pkg::OFS_STATUS, 32'h2400);
    wr(clsc_pkg::OFS_STATUS, 16'h2000);
    rd(clsc_pkg::OFS_STATUS, 32'h0);
    wr(clsc_pkg::OFS_CORE, 16'h0024);
  endtask
  task automatic t_exc;
    @(posedge mclk);
    exc <= '{req:1'b1, req_level:4'h3, default:'0};
    @(negedge mclk);
    chk(32'(exc_accept), 32'h1);
    @(posedge mclk);
    exc.take <= 1'b1;
    tick;
    @(negedge mclk);
    chk({27'h0, exc_accept, cpu_level}, 32'h3);
    rd(clsc_pkg::OFS_STATUS, 32'h0060);
    @(posedge mclk);
    exc.req_level <= 4'h9;
    exc.take <= 1'b1;
    tick;
    rd(clsc_pkg::OFS_CORE, 32'h002c);
    @(posedge mclk);
    exc <= '{ret:1'b1, ret_low:8'h40, default:'0};
    tick;
    chk(32'(cpu_level), 32'ha);
    wr(clsc_pkg::OFS_CORE, 16'h0024);
    chk(32'(cpu_level), 32'h2);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog, far beyond the roughly 160 cycles needed
  initial
  begin
    #(3000 * 100);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_cfg();
    t_loop();
    t_rep();
    t_alu();
    t_dsp();
    t_exc();
    tally_and_finish();
  end
endmodule // tb_core_loop_status_control
`default_nettype wire
